// file: qsf_pkg.sv
package qsf_pkg;
  // array geometry
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_COUNT = 4096;
  localparam int ADDR_W = 20;
  localparam int SECTOR_PAGES = 16;
  localparam int BLK32_PAGES = 128;
  localparam int BLK64_PAGES = 256;
  localparam int PAGE_SHIFT = 8;
  localparam int SECTOR_SHIFT = 12;
  localparam int BLK32_SHIFT = 15;
  localparam int BLK64_SHIFT = 16;
  localparam int UID_W = 64;
  localparam int OPC_W = 8;
  // lane modes
  typedef enum logic [1:0] {
    QSF_SINGLE = 2'b00,
    QSF_DUAL = 2'b01,
    QSF_QUAD = 2'b10
  } qsf_lane_type;
  // erase sizes
  typedef enum logic [1:0] {
    QSF_ERASE_SECTOR = 2'b00,
    QSF_ERASE_BLK32 = 2'b01,
    QSF_ERASE_BLK64 = 2'b10,
    QSF_ERASE_CHIP = 2'b11
  } qsf_erase_type;
  // interface states
  typedef enum logic [1:0] {
    QSF_ARMING = 2'b00,
    QSF_IDLE = 2'b01,
    QSF_ACTIVE = 2'b10
  } qsf_state_type;
  // protection bits from the status registers
  typedef struct packed {
    logic protect_complement_bit;
    logic sector_granularity_bit;
    logic top_bottom_select_bit;
    logic block_protect_bit2;
    logic block_protect_bit1;
    logic block_protect_bit0;
    logic status_write_guard_bit0;
  } qsf_prot_type;
  // pin-facing lane bundle
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } qsf_lane_drive_type;
endpackage

// file: qsf_pin_if.sv
`timescale 1ns/1ps
module qsf_pin_if
  import qsf_pkg::*;
#(
  parameter logic [UID_W-1:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // arbitrary value
  parameter logic [23:0] ID_CODE = 24'hA5_5A_14 // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // serial pins
  input wire logic spi_clk,
  input wire logic chip_sel_b,
  input wire logic [3:0] data_lane_in,
  output logic [3:0] data_lane_out,
  output logic [3:0] data_lane_oe,
  // core side: status bits and lane mode requested by the decoded opcode
  input wire logic quad_lane_enable_bit,
  input wire qsf_prot_type prot,
  input wire qsf_lane_type req_lane_mode,
  input wire logic read_phase,
  input wire logic [3:0] read_nibble,
  input wire logic internal_busy,
  // core side: captured fields
  output logic [OPC_W-1:0] opcode,
  output logic opcode_valid,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic lane_shift,
  output logic selected,
  output logic paused,
  output logic status_write_allowed,
  output logic [UID_W-1:0] unique_id,
  output logic [23:0] id_code,
  output logic [ADDR_W-1:0] region_lo,
  output logic [ADDR_W-1:0] region_hi,
  output logic region_valid,
  output logic busy_hold
);
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] hold_s;
    logic [2:0] wp_s;
    logic [3:0] lane_a;
    logic [3:0] lane_b;
    logic sclk_st;
    logic cs_st;
    logic hold_st;
    logic wp_st;
    qsf_state_type state;
    logic pause;
    logic pause_pend;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [OPC_W-1:0] opc;
    logic opc_v;
    logic [7:0] rxb;
    logic rxb_v;
    logic sh_pulse;
    qsf_lane_drive_type drv;
  } qsf_st_type;

  qsf_st_type s_reg, s_next;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, hold_eff_b;
  logic [2:0] step;
  logic [3:0] rx_bits;
  qsf_lane_type mode;

  always_comb begin
    s_next = s_reg;
    s_next.opc_v = 1'b0;
    s_next.rxb_v = 1'b0;
    s_next.sh_pulse = 1'b0;
    // three-stage sync; change counts when second and third agree
    s_next.sclk_s = {s_reg.sclk_s[1:0], spi_clk};
    s_next.cs_s = {s_reg.cs_s[1:0], chip_sel_b};
    s_next.hold_s = {s_reg.hold_s[1:0], data_lane_in[3]};
    // write-protect is a pin too, so it gets the same three-stage treatment
    s_next.wp_s = {s_reg.wp_s[1:0], data_lane_in[2]};
    s_next.lane_a = data_lane_in;
    s_next.lane_b = s_reg.lane_a;
    if (s_reg.sclk_s[2] == s_reg.sclk_s[1]) s_next.sclk_st = s_reg.sclk_s[2];
    if (s_reg.cs_s[2] == s_reg.cs_s[1]) s_next.cs_st = s_reg.cs_s[2];
    if (s_reg.hold_s[2] == s_reg.hold_s[1]) s_next.hold_st = s_reg.hold_s[2];
    if (s_reg.wp_s[2] == s_reg.wp_s[1]) s_next.wp_st = s_reg.wp_s[2];
    sclk_rise = (s_next.sclk_st & ~s_reg.sclk_st);
    sclk_fall = (~s_next.sclk_st & s_reg.sclk_st);
    cs_fall = (~s_next.cs_st & s_reg.cs_st);
    cs_rise = (s_next.cs_st & ~s_reg.cs_st);
    // pause pin is a data lane once quad is enabled
    hold_eff_b = quad_lane_enable_bit | s_next.hold_st;
    // quad requests fall back to single without the enable bit
    mode = req_lane_mode;
    if (req_lane_mode == QSF_QUAD && !quad_lane_enable_bit) mode = QSF_SINGLE;
    unique case (mode)
      QSF_SINGLE: step = 3'd1;
      QSF_DUAL: step = 3'd2;
      default: step = 3'd4;
    endcase
    rx_bits = s_reg.lane_b; // aligned with the synced clock edge
    // pause entry and exit both wait for a low clock
    if (s_reg.state == QSF_ACTIVE) begin
      if ((~hold_eff_b) != s_reg.pause) begin
        if (!s_next.sclk_st && (!s_reg.pause_pend || sclk_fall || !s_reg.sclk_st)) begin
          s_next.pause = ~hold_eff_b;
          s_next.pause_pend = 1'b0;
        end else begin
          s_next.pause_pend = 1'b1;
        end
      end else begin
        s_next.pause_pend = 1'b0;
      end
    end
    unique case (s_reg.state)
      QSF_ARMING: begin
        // nothing is taken until select has been seen falling
        if (cs_fall) begin
          s_next.state = QSF_ACTIVE;
          s_next.bit_cnt = 4'd0;
          s_next.shreg = 8'h00;
        end
      end
      QSF_IDLE: begin
        if (cs_fall) begin
          s_next.state = QSF_ACTIVE;
          s_next.bit_cnt = 4'd0;
          s_next.shreg = 8'h00;
        end
      end
      QSF_ACTIVE: begin
        if (cs_rise || s_next.cs_st) begin
          // partial opcode and pause state dropped at deselect
          s_next.state = QSF_IDLE;
          s_next.bit_cnt = 4'd0;
          s_next.pause = 1'b0;
          s_next.pause_pend = 1'b0;
        end else if (!s_next.pause) begin
          if (sclk_rise && !read_phase) begin
            s_next.sh_pulse = 1'b1;
            if (!s_reg.opc_v && s_reg.bit_cnt < 4'd8) begin
              // opcode always arrives on one lane, msb first
              s_next.shreg = {s_reg.shreg[6:0], rx_bits[0]};
              s_next.bit_cnt = s_reg.bit_cnt + 4'd1;
            end
            if (s_reg.bit_cnt == 4'd7 && !s_reg.opc_v) begin
              s_next.opc = {s_reg.shreg[6:0], rx_bits[0]};
              s_next.opc_v = 1'b1;
              s_next.bit_cnt = 4'd8;
            end else if (s_reg.bit_cnt >= 4'd8) begin
              unique case (mode)
                QSF_SINGLE: s_next.shreg = {s_reg.shreg[6:0], rx_bits[0]};
                QSF_DUAL: s_next.shreg = {s_reg.shreg[5:0], rx_bits[1:0]};
                default: s_next.shreg = {s_reg.shreg[3:0], rx_bits};
              endcase
              s_next.bit_cnt = 4'(s_reg.bit_cnt + {1'b0, step});
              // one bit wider than the counter, otherwise the byte end wraps to zero
              if (({1'b0, s_reg.bit_cnt} + {2'b00, step}) >= 5'd16) begin
                s_next.rxb = s_next.shreg;
                s_next.rxb_v = 1'b1;
                s_next.bit_cnt = 4'd8;
              end
            end
          end
          if (sclk_fall && read_phase) begin
            s_next.sh_pulse = 1'b1;
            unique case (mode)
              QSF_SINGLE: begin
                s_next.drv.out = {3'b000, read_nibble[0]} << 1;
                s_next.drv.oe = 4'b0010;
              end
              QSF_DUAL: begin
                s_next.drv.out = {2'b00, read_nibble[1:0]};
                s_next.drv.oe = 4'b0011;
              end
              default: begin
                s_next.drv.out = read_nibble;
                s_next.drv.oe = 4'b1111;
              end
            endcase
          end
          if (!read_phase) s_next.drv.oe = 4'b0000;
        end
      end
      default: s_next.state = QSF_IDLE;
    endcase
    // floating lanes while deselected or paused
    if (s_next.state != QSF_ACTIVE || s_next.pause) s_next.drv.oe = 4'b0000;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.sclk_s <= 3'b000;
      // select held low through reset must not read as a falling edge
      s_reg.cs_s <= 3'b000;
      s_reg.hold_s <= 3'b111;
      s_reg.wp_s <= 3'b111;
      s_reg.cs_st <= 1'b0;
      s_reg.hold_st <= 1'b1;
      s_reg.wp_st <= 1'b1;
      s_reg.state <= QSF_ARMING;
    end else begin
      s_reg <= s_next;
    end
  end

  assign data_lane_out = s_reg.drv.out;
  assign data_lane_oe = s_reg.drv.oe;
  assign opcode = s_reg.opc;
  assign opcode_valid = s_reg.opc_v;
  assign rx_byte = s_reg.rxb;
  assign rx_byte_valid = s_reg.rxb_v;
  assign lane_shift = s_reg.sh_pulse;
  assign selected = (s_reg.state == QSF_ACTIVE);
  assign paused = s_reg.pause;
  // an internal cycle is not stopped by deselect
  assign busy_hold = internal_busy;
  // status writes gated by write-protect unless quad owns the pin
  assign status_write_allowed = !(prot.status_write_guard_bit0 && !quad_lane_enable_bit
                                  && !s_reg.wp_st);
  assign unique_id = UNIQUE_ID;
  assign id_code = ID_CODE;

  // protected region: sector or 64K-block granularity
  logic [2:0] bp;
  logic [ADDR_W-1:0] span, lo, hi;
  always_comb begin
    bp = {prot.block_protect_bit2, prot.block_protect_bit1, prot.block_protect_bit0};
    span = '0;
    if (bp != 3'b000) begin
      if (prot.sector_granularity_bit) begin
        span = ADDR_W'((1 << SECTOR_SHIFT) << ((bp > 3'd5) ? 3'd4 : bp - 3'd1));
      end else begin
        span = ADDR_W'((1 << BLK64_SHIFT) << ((bp > 3'd4) ? 3'd4 : bp - 3'd1));
      end
    end
    if (bp == 3'b111 && !prot.sector_granularity_bit) span = '0;
    if (prot.top_bottom_select_bit) begin
      lo = '0;
      hi = span - ADDR_W'(1);
    end else begin
      lo = ADDR_W'(PAGE_COUNT * PAGE_BYTES) - span;
      hi = '1;
    end
    region_lo = lo;
    region_hi = hi;
    region_valid = (span != '0) || (bp == 3'b111);
    if (bp == 3'b111 && !prot.sector_granularity_bit) begin
      region_lo = '0;
      region_hi = '1;
    end
    if (prot.protect_complement_bit) begin
      region_valid = !region_valid || !(region_lo == '0 && region_hi == '1);
      if (prot.top_bottom_select_bit) begin
        region_lo = hi + ADDR_W'(1);
        region_hi = '1;
      end else begin
        region_lo = '0;
        region_hi = lo - ADDR_W'(1);
      end
    end
  end

  // page program bytes are counted up to one page (PAGE_BYTES), then the count holds
  localparam int PAGE_CNT_W = PAGE_SHIFT + 1;
  logic [PAGE_CNT_W-1:0] pg_bytes_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !selected) pg_bytes_reg <= '0;
    else if (s_reg.rxb_v && pg_bytes_reg < PAGE_CNT_W'(PAGE_BYTES)) pg_bytes_reg <= pg_bytes_reg + 1'b1;
  end

  // deselect and pause both leave every lane floating
  sequence desel_s;
    s_reg.cs_st;
  endsequence
  property float_p;
    @(posedge ref_clk) disable iff (!rst_b) desel_s |-> data_lane_oe == 4'b0000;
  endproperty
  float_lanes_a: assert property (float_p) else $error("lanes driven while deselected");
  arm_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_reg.state == QSF_ARMING) |-> !opcode_valid) else $error("opcode before select fall");
  sel_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_reg.state == QSF_IDLE && cs_fall |=> selected) else $error("select fall not taken");
  pause_float_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    paused |-> data_lane_oe == 4'b0000) else $error("lanes driven in pause");
  pause_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    paused && s_next.pause && !s_next.cs_st |=> $stable(s_reg.bit_cnt) && $stable(s_reg.shreg))
    else $error("input taken during pause");
  pause_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    paused && selected |=> $stable(opcode)) else $error("opcode changed in pause");
  quad_nopause_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    quad_lane_enable_bit && !paused |=> !paused) else $error("pause taken with quad enabled");
  quad_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !quad_lane_enable_bit |-> !data_lane_oe[3]) else $error("lane 3 driven without quad");
  single_lane_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(data_lane_oe[1]) && !data_lane_oe[0] |-> $past(s_reg.sclk_st, 1) && !s_reg.sclk_st)
    else $error("single lane drive off falling edge");
  // read and opcode checks follow the synced clock edges, not the raw pins
  sequence rd_fall_s;
    selected && read_phase && sclk_fall && !s_next.cs_st && !s_next.pause;
  endsequence
  sequence quad_mode_s;
    mode == QSF_QUAD;
  endsequence
  quad_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rd_fall_s ##0 quad_mode_s |=> data_lane_oe == 4'hF && data_lane_out == $past(read_nibble))
    else $error("quad read not on all four lanes");
  sequence op_rise_s;
    selected && sclk_rise && !read_phase && !s_next.cs_st && !s_next.pause && !s_reg.opc_v && s_reg.bit_cnt < 4'd8;
  endsequence
  op_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    op_rise_s |=> s_reg.shreg[0] == $past(s_reg.lane_b[0])) else $error("opcode bit not taken from lane 0");
  page_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pg_bytes_reg <= PAGE_CNT_W'(PAGE_BYTES)) else $error("page byte count overflow");
  desel_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(selected) && $rose(s_reg.cs_st) |-> !selected && s_reg.bit_cnt == 4'd0)
    else $error("partial opcode kept");
endmodule

// file: qsf_host_model.sv
`timescale 1ns/1ps
module qsf_host_model
  import qsf_pkg::*;
(
  // timing reference
  input wire logic ref_clk,
  // pins toward the device
  output logic spi_clk,
  output logic chip_sel_b,
  output logic [3:0] lane_drv
);
  initial begin
    spi_clk = 1'b0;
    chip_sel_b = 1'b0; // low from power-up, so no select fall has been seen yet
    lane_drv = 4'hC; // lanes 2 and 3 rest at their pull-up level
  end
  // four system cycles a half period: 80 ns link period, well under the ceiling
  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic select();
    chip_sel_b = 1'b1;
    half();
    chip_sel_b = 1'b0;
    half();
  endtask
  task automatic deselect();
    spi_clk = 1'b0;
    half();
    chip_sel_b = 1'b1;
    lane_drv[0] = ~lane_drv[0]; // a released lane must not keep showing the last bit
    half();
  endtask
  // top n bits of v on lane 0, msb first, set while the clock is low
  task automatic shift(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      lane_drv[0] = v[i];
      half();
      spi_clk = 1'b1;
      half();
      spi_clk = 1'b0;
    end
  endtask
  // read clocks: host side of lane 0 toggles so a stale level is never mistaken for data
  task automatic clocks(input int n);
    repeat (n) begin
      lane_drv[0] = ~lane_drv[0];
      half();
      spi_clk = 1'b1;
      half();
      spi_clk = 1'b0;
    end
  endtask
  // clock parked between frames; a high park is clock mode 3
  task automatic park(input logic lvl);
    spi_clk = lvl;
    half();
  endtask
  // one byte msb first over w lanes (2 or 4); lanes 2 and 3 return to pull-up level after
  task automatic shift_lanes(input logic [7:0] v, input int w);
    for (int i = 8 - w; i >= 0; i -= w) begin
      if (w == 4) lane_drv = v[i +: 4];
      else lane_drv = {2'b11, v[i +: 2]};
      half();
      spi_clk = 1'b1;
      half();
      spi_clk = 1'b0;
    end
    lane_drv = 4'hC;
  endtask
  // select stays low across any pause made here
  task automatic set_pin(input int idx, input logic v);
    lane_drv[idx] = v;
    half();
  endtask
endmodule

// file: qsf_pin_if_tb.sv
`timescale 1ns/1ps
module qsf_pin_if_tb
  import qsf_pkg::*;
;
  localparam logic [UID_W-1:0] UID_VAL = 64'h5A5A_0F0F_C3C3_1234; // arbitrary value
  localparam logic [23:0] IDC_VAL = 24'h3C_96_11; // arbitrary value
  logic ref_clk, rst_b, spi_clk, chip_sel_b, quad_lane_enable_bit, read_phase, internal_busy;
  logic [3:0] lane_drv, data_lane_in, data_lane_out, data_lane_oe, read_nibble;
  qsf_prot_type prot;
  qsf_lane_type req_lane_mode;
  logic [7:0] opcode, rx_byte;
  logic opcode_valid, rx_byte_valid, lane_shift, selected, paused, status_write_allowed, region_valid, busy_hold;
  logic [UID_W-1:0] unique_id;
  logic [23:0] id_code;
  logic [ADDR_W-1:0] region_lo, region_hi;
  int errors = 0;
  int total_checks = 0;
  int opc_cnt = 0;
  int rx_cnt = 0;
  int rx0;
  int sh_cnt = 0;
  int sh0;
  qsf_lane_type lane_tab [4] = '{QSF_SINGLE, QSF_DUAL, QSF_QUAD, QSF_QUAD};
  logic [3:0] oe_tab [4] = '{4'h2, 4'h3, 4'hF, 4'h2};
  // wire level: a driving device wins, otherwise the host side
  assign data_lane_in = (data_lane_oe & data_lane_out) | (~data_lane_oe & lane_drv);
  qsf_host_model i_host (.ref_clk(ref_clk), .spi_clk(spi_clk), .chip_sel_b(chip_sel_b), .lane_drv(lane_drv));
  qsf_pin_if #(.UNIQUE_ID(UID_VAL), .ID_CODE(IDC_VAL)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .spi_clk(spi_clk), .chip_sel_b(chip_sel_b),
    .data_lane_in(data_lane_in), .data_lane_out(data_lane_out), .data_lane_oe(data_lane_oe),
    .quad_lane_enable_bit(quad_lane_enable_bit), .prot(prot), .req_lane_mode(req_lane_mode),
    .read_phase(read_phase), .read_nibble(read_nibble), .internal_busy(internal_busy),
    .opcode(opcode), .opcode_valid(opcode_valid), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .lane_shift(lane_shift), .selected(selected), .paused(paused), .status_write_allowed(status_write_allowed),
    .unique_id(unique_id), .id_code(id_code), .region_lo(region_lo), .region_hi(region_hi),
    .region_valid(region_valid), .busy_hold(busy_hold));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // pulses last one cycle, so they are counted rather than sampled
  always @(posedge ref_clk) begin
    if (opcode_valid === 1'b1) opc_cnt++;
    if (rx_byte_valid === 1'b1) rx_cnt++;
    if (lane_shift === 1'b1) sh_cnt++;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    quad_lane_enable_bit = 1'b0;
    prot = '0;
    req_lane_mode = QSF_SINGLE;
    read_phase = 1'b0;
    read_nibble = 4'hA;
    internal_busy = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    check(PAGE_COUNT * PAGE_BYTES, 64'd1048576);
    check(SECTOR_PAGES * PAGE_BYTES, 64'd4096);
    i_host.shift(8'hFF, 8);
    i_host.half();
    check(opc_cnt, 0);
    i_host.deselect();
    check(data_lane_oe, 4'h0);
    check(selected, 1'b0);
    i_host.select();
    i_host.shift(8'h00, 5);
    i_host.deselect();
    i_host.select();
    check(selected, 1'b1);
    i_host.shift(8'h81, 8);
    i_host.half();
    check(opc_cnt, 1);
    check(opcode, 8'h81);
    sh0 = sh_cnt;
    i_host.shift(8'h3C, 8);
    i_host.half();
    check(rx_cnt, 1);
    check(rx_byte, 8'h3C);
    check(sh_cnt, sh0 + 8);
    i_host.deselect();
    for (int k = 0; k < 4; k++) begin
      quad_lane_enable_bit = (k == 2);
      req_lane_mode = lane_tab[k];
      i_host.select();
      i_host.shift(8'h0B, 8);
      read_phase = 1'b1;
      i_host.clocks(1);
      i_host.half();
      check(data_lane_oe, oe_tab[k]);
      if (k == 2) check(data_lane_out, 4'hA);
      read_phase = 1'b0;
      i_host.deselect();
      check(data_lane_oe, 4'h0);
    end
    quad_lane_enable_bit = 1'b1;
    req_lane_mode = QSF_QUAD;
    rx0 = rx_cnt;
    i_host.select();
    i_host.shift(8'h32, 8);
    i_host.shift_lanes(8'hA5, 4);
    i_host.half();
    check(rx_byte, 8'hA5);
    i_host.deselect();
    quad_lane_enable_bit = 1'b0;
    req_lane_mode = QSF_DUAL;
    i_host.select();
    i_host.shift(8'hBB, 8);
    i_host.shift_lanes(8'h6C, 2);
    i_host.half();
    check(rx_cnt, rx0 + 2);
    check(rx_byte, 8'h6C);
    i_host.deselect();
    quad_lane_enable_bit = 1'b0;
    req_lane_mode = QSF_SINGLE;
    i_host.select();
    i_host.shift(8'h02, 8);
    i_host.shift(8'h96, 4);
    rx0 = rx_cnt;
    i_host.set_pin(3, 1'b0);
    i_host.half();
    check(paused, 1'b1);
    check(data_lane_oe, 4'h0);
    i_host.shift(8'hFF, 4);
    i_host.set_pin(3, 1'b1);
    i_host.half();
    check(paused, 1'b0);
    i_host.shift(8'h60, 4);
    i_host.half();
    check(rx_cnt, rx0 + 1);
    check(rx_byte, 8'h96);
    i_host.deselect();
    quad_lane_enable_bit = 1'b1;
    i_host.select();
    i_host.set_pin(3, 1'b0);
    i_host.half();
    check(paused, 1'b0);
    i_host.set_pin(3, 1'b1);
    i_host.deselect();
    quad_lane_enable_bit = 1'b0;
    i_host.park(1'b1);
    i_host.select();
    i_host.park(1'b0);
    i_host.shift(8'h9F, 8);
    i_host.half();
    check(opcode, 8'h9F);
    i_host.park(1'b1);
    i_host.deselect();
    prot.status_write_guard_bit0 = 1'b1;
    i_host.set_pin(2, 1'b0);
    i_host.half();
    check(status_write_allowed, 1'b0);
    quad_lane_enable_bit = 1'b1;
    i_host.half();
    check(status_write_allowed, 1'b1);
    quad_lane_enable_bit = 1'b0;
    i_host.set_pin(2, 1'b1);
    i_host.half();
    check(status_write_allowed, 1'b1);
    prot = '0;
    internal_busy = 1'b1;
    i_host.half();
    check(busy_hold, 1'b1);
    check(region_valid, 1'b0);
    check(unique_id, UID_VAL);
    check(id_code, IDC_VAL);
    prot.sector_granularity_bit = 1'b1;
    prot.top_bottom_select_bit = 1'b1;
    prot.block_protect_bit0 = 1'b1;
    i_host.half();
    check(region_lo, 64'h0);
    check(region_hi, 64'(SECTOR_PAGES * PAGE_BYTES - 1));
    check(region_valid, 1'b1);
    prot = '0;
    {prot.block_protect_bit2, prot.block_protect_bit1, prot.block_protect_bit0} = 3'b111;
    i_host.half();
    check(region_lo, 64'h0);
    check(region_hi, 64'(PAGE_COUNT * PAGE_BYTES - 1));
    check(region_valid, 1'b1);
    internal_busy = 1'b0;
    results();
  end
endmodule
